//--- core/dcache_tag_snoop_ctrl.sv
// =====================================================================
// data cache tag, translation buffer and snoop controller
// assumes pipeline, tablewalker and bus interface on the same clock;
// requests are levels held until the matching done or ack
// =====================================================================
// Operation
// - non-cacheable access looks up translation, stalls; miss asks tablewalker
// - restart read on data arrival, write on memory or io accept
// - tag entry holds pa 35..12 and a valid bit
// - translation entry holds pa, context, permissions, c, m, va 31..20
// - hit needs tag equal translation pa, context match, permission pass
// - cache miss with translation miss requests translation fetch
// - read miss, or write miss with write-back, with translation hit requests line fill by pa
// - first doubleword written resumes pipeline, rest fill in background
// - access to unwritten doubleword of filling line stalls
// - store alternate 0x37 clears all valid bits, no write-back
// - flush or asi 0x10..0x14 clears line by va 13..5, both caches
// - no caching if page c clear, mmu off or dcache allow off
// - device access to cached data waits flush; dirty written first
// - snoop ram 512x19 written with pa 29..12 and valid on fill
// - snoop index is va 13..12 above pa 11..5
// - four snoop lookups, one per va 13..12 value
// - snoop hit forms line index and flushes that line
// - dirty snooped line written back before flush acknowledged
// - snoop miss forwards device access to bus controller
// - snoop ram updated always; looked up only when enabled
// - va 13..5 selects one of 512 lines
// - write-through writes go to memory, dirty never set
`timescale 1ns/1ps

module dcache_tag_snoop_ctrl #(
    parameter int TLB_ENTRIES = 4
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic mmuEnable,
    input wire logic dcacheAllowBit,
    input wire logic snoopEnableBit,
    input wire logic writeBack,
    input wire logic memReq,
    input wire logic memWr,
    input wire logic [31:0] memVa,
    input wire logic [7:0] memCtx,
    input wire logic flushInsn,
    input wire logic asiStore,
    input wire logic [7:0] asiNum,
    input wire logic twDone,
    input wire logic [23:0] twPa,
    input wire logic [7:0] twCtx,
    input wire logic [2:0] twPerm,
    input wire logic twCacheable,
    input wire logic twModified,
    input wire logic [11:0] twVa,
    input wire logic rdDwValid,
    input wire logic ncDone,
    input wire logic wbDone,
    input wire logic dvmaReq,
    input wire logic [29:0] dvmaPa,
    output logic stall_r,
    output logic accDone_r,
    output logic accFault_r,
    output logic xlateReq_r,
    output logic ncReq_r,
    output logic memWrReq_r,
    output logic fillReq_r,
    output logic [32:0] fillPa_r,
    output logic wbReq_r,
    output logic [8:0] wbIdx_r,
    output logic icFlushReq_r,
    output logic [8:0] icFlushIdx_r,
    output logic dvmaFwd_r
);
    localparam int PW = $clog2(TLB_ENTRIES);

    generate
        if (TLB_ENTRIES < 2 || TLB_ENTRIES > 64) begin : g_chk
            $error("TLB_ENTRIES out of range");
        end
    endgenerate

    // permission check for one access
    function automatic logic permOk(input logic [2:0] p, input logic w);
        permOk = w ? p[dcache_ctrl_pkg::PERM_WR] : p[dcache_ctrl_pkg::PERM_RD];
    endfunction

    // =================================================================
    // storage
    // =================================================================
    logic [23:0] tagRam [dcache_ctrl_pkg::LINES];
    logic [17:0] snpRam [dcache_ctrl_pkg::LINES];
    logic [511:0] valid_r, valid_nxt, dirty_r, dirty_nxt;
    logic [511:0] snpV_r, snpV_nxt;
    logic [TLB_ENTRIES-1:0] tlbV_r, tlbV_nxt;
    logic [23:0] tlbPa [TLB_ENTRIES];
    logic [7:0] tlbCtx [TLB_ENTRIES];
    logic [2:0] tlbPerm [TLB_ENTRIES];
    logic tlbC [TLB_ENTRIES];
    logic tlbM [TLB_ENTRIES];
    logic [11:0] tlbVa [TLB_ENTRIES];
    logic [PW-1:0] tlbPtr_r, tlbPtr_nxt;

    dcache_ctrl_pkg::main_state_t mState_r, mState_nxt;
    dcache_ctrl_pkg::snoop_state_t sState_r, sState_nxt;
    logic fillAct_r, fillAct_nxt;
    logic [2:0] fillCnt_r, fillCnt_nxt;
    logic [1:0] fillStart_r, fillStart_nxt;
    logic [8:0] fillIdx_r, fillIdx_nxt;
    logic [1:0] sCnt_r, sCnt_nxt;
    logic [29:0] sPa_r, sPa_nxt;
    logic stall_nxt, accDone_nxt, accFault_nxt, xlateReq_nxt, ncReq_nxt;
    logic memWrReq_nxt, fillReq_nxt, wbReq_nxt, icFlushReq_nxt;
    logic dvmaFwd_nxt;
    logic [32:0] fillPa_nxt;
    logic [8:0] wbIdx_nxt, icFlushIdx_nxt;

    // =================================================================
    // lookup
    // =================================================================
    logic [8:0] idx, sIdx;
    logic tHit, tC, tagHit, cacheOk, hazard, sHit, fillFirst, tlbLoad;
    logic [23:0] tPa;
    logic [2:0] tPerm;
    logic [1:0] dwOff;

    // translation match on va 31..20 and context
    always_comb begin
        tHit = 1'b0;
        tC = 1'b0;
        tPa = '0;
        tPerm = '0;
        for (int i = 0; i < TLB_ENTRIES; i++) begin
            if (tlbV_r[i] && tlbVa[i] == memVa[31:20] &&
                tlbCtx[i] == memCtx) begin
                tHit = 1'b1;
                tC = tlbC[i];
                tPa = tlbPa[i];
                tPerm = tlbPerm[i];
            end
        end
    end

    // tag compare, caching permission and fill hazard
    assign idx = memVa[13:5];
    assign tagHit = valid_r[idx] && tagRam[idx] == tPa && tHit;
    assign cacheOk = mmuEnable && dcacheAllowBit && tC;
    assign dwOff = memVa[4:3] - fillStart_r;
    assign hazard = fillAct_r && fillIdx_r == idx &&
                    {1'b0, dwOff} >= fillCnt_r;
    assign sIdx = {sCnt_r, sPa_r[11:5]};
    assign sHit = snpV_r[sIdx] &&
                  snpRam[sIdx] == sPa_r[29:12];
    assign fillFirst = mState_r == dcache_ctrl_pkg::M_FILL && rdDwValid;
    assign tlbLoad = mState_r == dcache_ctrl_pkg::M_XLATE && twDone;

    // =================================================================
    // pipeline side state machine
    // =================================================================
    always_comb begin
        mState_nxt = mState_r;
        accDone_nxt = 1'b0;
        accFault_nxt = 1'b0;
        memWrReq_nxt = 1'b0;
        xlateReq_nxt = 1'b0;
        ncReq_nxt = 1'b0;
        fillReq_nxt = fillReq_r;
        fillPa_nxt = fillPa_r;
        fillAct_nxt = fillAct_r;
        fillCnt_nxt = fillCnt_r;
        fillStart_nxt = fillStart_r;
        fillIdx_nxt = fillIdx_r;
        tlbPtr_nxt = tlbPtr_r;
        case (mState_r)
            dcache_ctrl_pkg::M_IDLE: begin
                if (memReq && !accDone_r) begin
                    if (!tHit) begin
                        mState_nxt = dcache_ctrl_pkg::M_XLATE;
                        xlateReq_nxt = 1'b1;
                    end else if (!permOk(tPerm, memWr)) begin
                        accDone_nxt = 1'b1;
                        accFault_nxt = 1'b1;
                    end else if (!cacheOk) begin
                        mState_nxt = dcache_ctrl_pkg::M_NC;
                        ncReq_nxt = 1'b1;
                    end else if (tagHit) begin
                        accDone_nxt = !hazard;
                        memWrReq_nxt = !hazard && memWr &&
                                       !writeBack;
                    end else if (memWr && !writeBack) begin
                        accDone_nxt = 1'b1;
                        memWrReq_nxt = 1'b1;
                    end else if (!fillAct_r) begin
                        if (valid_r[idx] && dirty_r[idx] && writeBack) begin
                            if (sState_r == dcache_ctrl_pkg::S_IDLE ||
                                sState_r == dcache_ctrl_pkg::S_FWD) begin
                                mState_nxt = dcache_ctrl_pkg::M_WB;
                            end
                        end else begin
                            mState_nxt = dcache_ctrl_pkg::M_FILL;
                            fillReq_nxt = 1'b1;
                            fillPa_nxt = {tPa, memVa[11:3]};
                        end
                    end
                end
            end
            dcache_ctrl_pkg::M_XLATE: begin
                xlateReq_nxt = !twDone;
                if (twDone) begin
                    mState_nxt = dcache_ctrl_pkg::M_IDLE;
                    tlbPtr_nxt = tlbPtr_r + 1'b1;
                end
            end
            dcache_ctrl_pkg::M_NC: begin
                ncReq_nxt = !ncDone;
                if (ncDone) begin
                    mState_nxt = dcache_ctrl_pkg::M_IDLE;
                    accDone_nxt = 1'b1;
                end
            end
            dcache_ctrl_pkg::M_WB: begin
                if (wbDone) begin
                    mState_nxt = dcache_ctrl_pkg::M_FILL;
                    fillReq_nxt = 1'b1;
                    fillPa_nxt = {tPa, memVa[11:3]};
                end
            end
            dcache_ctrl_pkg::M_FILL: begin
                if (rdDwValid) begin
                    mState_nxt = dcache_ctrl_pkg::M_IDLE;
                    fillReq_nxt = 1'b0;
                    fillAct_nxt = 1'b1;
                    fillCnt_nxt = 3'h1;
                    fillStart_nxt = memVa[4:3];
                    fillIdx_nxt = idx;
                    accDone_nxt = !memWr || writeBack;
                end
            end
            default: mState_nxt = dcache_ctrl_pkg::M_IDLE;
        endcase
        // remaining doublewords land in the background
        if (fillAct_r && rdDwValid) begin
            fillCnt_nxt = fillCnt_r + 3'h1;
            fillAct_nxt = fillCnt_r != 3'(dcache_ctrl_pkg::DW_PER_LINE - 1);
        end
    end

    // =================================================================
    // snoop state machine
    // =================================================================
    always_comb begin
        sState_nxt = sState_r;
        sCnt_nxt = sCnt_r;
        sPa_nxt = sPa_r;
        dvmaFwd_nxt = 1'b0;
        case (sState_r)
            dcache_ctrl_pkg::S_IDLE: begin
                if (dvmaReq && !dvmaFwd_r) begin
                    sPa_nxt = dvmaPa;
                    sCnt_nxt = 2'h0;
                    sState_nxt = snoopEnableBit ? dcache_ctrl_pkg::S_LOOK
                                                : dcache_ctrl_pkg::S_FWD;
                end
            end
            dcache_ctrl_pkg::S_LOOK: begin
                if (sHit && dirty_r[sIdx] && valid_r[sIdx] && writeBack) begin
                    if (mState_r != dcache_ctrl_pkg::M_WB) begin
                        sState_nxt = dcache_ctrl_pkg::S_WB;
                    end
                end else if (sCnt_r == 2'(dcache_ctrl_pkg::SNP_WAYS - 1)) begin
                    sState_nxt = dcache_ctrl_pkg::S_FWD;
                end else begin
                    sCnt_nxt = sCnt_r + 2'h1;
                end
            end
            dcache_ctrl_pkg::S_WB: begin
                if (wbDone) begin
                    if (sCnt_r == 2'(dcache_ctrl_pkg::SNP_WAYS - 1)) begin
                        sState_nxt = dcache_ctrl_pkg::S_FWD;
                    end else begin
                        sState_nxt = dcache_ctrl_pkg::S_LOOK;
                        sCnt_nxt = sCnt_r + 2'h1;
                    end
                end
            end
            dcache_ctrl_pkg::S_FWD: begin
                dvmaFwd_nxt = 1'b1;
                sState_nxt = dcache_ctrl_pkg::S_IDLE;
            end
            default: sState_nxt = dcache_ctrl_pkg::S_IDLE;
        endcase
    end

    // =================================================================
    // valid, dirty, write-back and flush outputs
    // =================================================================
    always_comb begin
        valid_nxt = valid_r;
        dirty_nxt = dirty_r;
        snpV_nxt = snpV_r;
        tlbV_nxt = tlbV_r;
        icFlushReq_nxt = 1'b0;
        icFlushIdx_nxt = icFlushIdx_r;
        if (tlbLoad) begin
            tlbV_nxt[tlbPtr_r] = 1'b1;
        end
        if (fillFirst) begin
            valid_nxt[idx] = 1'b1;
            dirty_nxt[idx] = 1'b0;
            snpV_nxt[idx] = 1'b1;
        end
        if (mState_r == dcache_ctrl_pkg::M_IDLE && memReq && tagHit &&
            cacheOk && memWr && writeBack && !hazard &&
            permOk(tPerm, memWr)) begin
            dirty_nxt[idx] = 1'b1;
        end
        if (mState_r == dcache_ctrl_pkg::M_WB && wbDone) begin
            dirty_nxt[idx] = 1'b0;
        end
        // snoop flush drops the line once clean
        if ((sState_r == dcache_ctrl_pkg::S_LOOK && sHit &&
             !(dirty_r[sIdx] && valid_r[sIdx] && writeBack)) ||
            (sState_r == dcache_ctrl_pkg::S_WB && wbDone)) begin
            valid_nxt[sIdx] = 1'b0;
            dirty_nxt[sIdx] = 1'b0;
            snpV_nxt[sIdx] = 1'b0;
        end
        if (flushInsn || (asiStore && asiNum >= dcache_ctrl_pkg::ASI_LINE_LO
                          && asiNum <= dcache_ctrl_pkg::ASI_LINE_HI)) begin
            valid_nxt[idx] = 1'b0;
            snpV_nxt[idx] = 1'b0;
            icFlushReq_nxt = 1'b1;
            icFlushIdx_nxt = idx;
        end
        if (asiStore && asiNum == dcache_ctrl_pkg::ASI_FLUSH_ALL) begin
            valid_nxt = '0;
            snpV_nxt = '0;
        end
        wbReq_nxt = mState_nxt == dcache_ctrl_pkg::M_WB ||
                    sState_nxt == dcache_ctrl_pkg::S_WB;
        wbIdx_nxt = (sState_nxt == dcache_ctrl_pkg::S_WB) ? sIdx : idx;
        stall_nxt = (memReq && !accDone_nxt && !accDone_r) ||
                    mState_nxt != dcache_ctrl_pkg::M_IDLE;
    end

    // memories: tags, snoop copy and translation entries
    always_ff @(posedge mclk) begin
        if (fillFirst) begin
            tagRam[idx] <= tPa;
            snpRam[idx] <= tPa[17:0];
        end
        if (tlbLoad) begin
            tlbPa[tlbPtr_r] <= twPa;
            tlbCtx[tlbPtr_r] <= twCtx;
            tlbPerm[tlbPtr_r] <= twPerm;
            tlbC[tlbPtr_r] <= twCacheable;
            tlbM[tlbPtr_r] <= twModified;
            tlbVa[tlbPtr_r] <= twVa;
        end
    end

    // state registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mState_r <= dcache_ctrl_pkg::M_IDLE;
            sState_r <= dcache_ctrl_pkg::S_IDLE;
            valid_r <= '0;
            dirty_r <= '0;
            snpV_r <= '0;
            tlbV_r <= '0;
            tlbPtr_r <= '0;
            fillAct_r <= 1'b0;
            fillCnt_r <= dcache_ctrl_pkg::CNT_RST;
            fillStart_r <= 2'h0;
            fillIdx_r <= 9'h000;
            sCnt_r <= 2'h0;
            sPa_r <= 30'h0000_0000;
            stall_r <= 1'b0;
            accDone_r <= 1'b0;
            accFault_r <= 1'b0;
            xlateReq_r <= 1'b0;
            ncReq_r <= 1'b0;
            memWrReq_r <= 1'b0;
            fillReq_r <= 1'b0;
            fillPa_r <= '0;
            wbReq_r <= 1'b0;
            wbIdx_r <= 9'h000;
            icFlushReq_r <= 1'b0;
            icFlushIdx_r <= 9'h000;
            dvmaFwd_r <= 1'b0;
        end else begin
            mState_r <= mState_nxt;
            sState_r <= sState_nxt;
            valid_r <= valid_nxt;
            dirty_r <= dirty_nxt;
            snpV_r <= snpV_nxt;
            tlbV_r <= tlbV_nxt;
            tlbPtr_r <= tlbPtr_nxt;
            fillAct_r <= fillAct_nxt;
            fillCnt_r <= fillCnt_nxt;
            fillStart_r <= fillStart_nxt;
            fillIdx_r <= fillIdx_nxt;
            sCnt_r <= sCnt_nxt;
            sPa_r <= sPa_nxt;
            stall_r <= stall_nxt;
            accDone_r <= accDone_nxt;
            accFault_r <= accFault_nxt;
            xlateReq_r <= xlateReq_nxt;
            ncReq_r <= ncReq_nxt;
            memWrReq_r <= memWrReq_nxt;
            fillReq_r <= fillReq_nxt;
            fillPa_r <= fillPa_nxt;
            wbReq_r <= wbReq_nxt;
            wbIdx_r <= wbIdx_nxt;
            icFlushReq_r <= icFlushReq_nxt;
            icFlushIdx_r <= icFlushIdx_nxt;
            dvmaFwd_r <= dvmaFwd_nxt;
        end
    end

endmodule

//--- core/dcache_ctrl_pkg.sv
// =====================================================================
// package for the data cache tag and snoop controller
// shared constants, field widths and state types
// assumes one core clock domain
// =====================================================================
package dcache_ctrl_pkg;

    // =================================================================
    // geometry and field widths
    // =================================================================
    localparam int LINES = 512;
    localparam int IDX_W = 9;
    localparam int TAG_W = 24;        // pa 35..12
    localparam int CTX_W = 8;
    localparam int VTAG_W = 12;       // va 31..20
    localparam int PERM_W = 3;
    localparam int SNP_W = 18;        // pa 29..12
    localparam int DW_PER_LINE = 4;
    localparam int SNP_WAYS = 4;      // va 13..12 permutations

    // =================================================================
    // alternate space codes
    // =================================================================
    localparam logic [7:0] ASI_FLUSH_ALL = 8'h37;
    localparam logic [7:0] ASI_LINE_LO = 8'h10;
    localparam logic [7:0] ASI_LINE_HI = 8'h14;

    // =================================================================
    // permission bit positions and reset values
    // =================================================================
    localparam int PERM_RD = 0;
    localparam int PERM_WR = 1;
    localparam logic [2:0] CNT_RST = 3'h0;

    // =================================================================
    // state machines
    // =================================================================
    typedef enum logic [4:0] {
        M_IDLE = 5'h01,
        M_XLATE = 5'h02,
        M_NC = 5'h04,
        M_WB = 5'h08,
        M_FILL = 5'h10
    } main_state_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_LOOK = 4'h2,
        S_WB = 4'h4,
        S_FWD = 4'h8
    } snoop_state_t;

endpackage

//--- bench/dcache_ctrl_chk.sv
// checker for the data cache tag and snoop controller
// assumes one clock domain and binding onto the controller's ports
`timescale 1ns/1ps
// =====================================================================
// port watcher
// =====================================================================
module dcache_ctrl_chk (
    input wire logic mclk, resetn, mmuEnable, dcacheAllowBit,
    input wire logic snoopEnableBit, writeBack, dvmaReq, flushInsn,
    input wire logic asiStore, rdDwValid, ncDone,
    input wire logic [7:0] asiNum,
    input wire logic [31:0] memVa,
    input wire logic stall_r, accDone_r, accFault_r, xlateReq_r,
    input wire logic ncReq_r, fillReq_r, wbReq_r, icFlushReq_r,
    input wire logic dvmaFwd_r,
    input wire logic [8:0] icFlushIdx_r
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    property p_reqStall; xlateReq_r || ncReq_r |-> stall_r; endproperty
    a_reqStall: assert property (p_reqStall)
        else $error("request outstanding without stall");
    property p_ncRestart; ncReq_r && ncDone |=> accDone_r; endproperty
    a_ncRestart: assert property (p_ncRestart)
        else $error("uncached access not completed after done");
    property p_fault; accFault_r |-> accDone_r; endproperty
    a_fault: assert property (p_fault)
        else $error("fault without completion");
    property p_fillResume;
        fillReq_r && rdDwValid |=> accDone_r && !fillReq_r;
    endproperty
    a_fillResume: assert property (p_fillResume)
        else $error("first doubleword did not resume pipeline");
    property p_noCache; fillReq_r |-> mmuEnable && dcacheAllowBit; endproperty
    a_noCache: assert property (p_noCache)
        else $error("line fill while caching is off");
    property p_lineFlush;
        flushInsn || asiStore && asiNum inside {[8'h10:8'h14]}
        |=> icFlushReq_r && icFlushIdx_r == $past(memVa[13:5]);
    endproperty
    a_lineFlush: assert property (p_lineFlush)
        else $error("line flush not passed on with its index");
    property p_dvmaOff; $rose(dvmaReq) && !snoopEnableBit |-> ##2 dvmaFwd_r;
    endproperty
    a_dvmaOff: assert property (p_dvmaOff)
        else $error("device access not forwarded in two cycles");
    property p_dvmaLook;
        $rose(dvmaReq) && snoopEnableBit && !writeBack
        |-> !dvmaFwd_r[*6] ##1 dvmaFwd_r;
    endproperty
    a_dvmaLook: assert property (p_dvmaLook)
        else $error("four lookups not followed by forward");
    property p_fwdPulse; dvmaFwd_r |=> !dvmaFwd_r; endproperty
    a_fwdPulse: assert property (p_fwdPulse)
        else $error("forward pulse longer than one cycle");
    property p_wtNoWb; $rose(wbReq_r) |-> $past(writeBack); endproperty
    a_wtNoWb: assert property (p_wtNoWb)
        else $error("write-back raised in write-through mode");
endmodule

bind dcache_tag_snoop_ctrl dcache_ctrl_chk u_chk (.mclk, .resetn,
    .mmuEnable, .dcacheAllowBit, .snoopEnableBit, .writeBack, .dvmaReq,
    .flushInsn, .asiStore, .rdDwValid, .ncDone, .asiNum, .memVa, .stall_r,
    .accDone_r, .accFault_r, .xlateReq_r, .ncReq_r, .fillReq_r, .wbReq_r,
    .icFlushReq_r, .dvmaFwd_r, .icFlushIdx_r);

//--- bench/dcache_pipe_partner.sv
// model of tablewalker and bus interface answering the controller
// assumes the controller's request levels and one core clock
`timescale 1ns/1ps
// =====================================================================
// far side responder
// =====================================================================
module dcache_pipe_partner (
    input wire logic mclk, resetn, slow, eC,
    input wire logic [31:0] memVa,
    input wire logic [7:0] memCtx,
    input wire logic [23:0] ePa,
    input wire logic xlateReq_r, fillReq_r, ncReq_r, wbReq_r,
    output logic twDone, rdDwValid, ncDone, wbDone,
    output logic twCacheable, twModified,
    output logic [23:0] twPa,
    output logic [7:0] twCtx,
    output logic [2:0] twPerm,
    output logic [11:0] twVa
);
    initial {twDone, rdDwValid, ncDone, wbDone} = '0;
    // entry fields scrambled outside the done pulse
    assign twPa = twDone ? ePa : ~ePa;
    assign twCtx = twDone ? memCtx : ~memCtx;
    assign twVa = twDone ? memVa[31:20] : ~memVa[31:20];
    assign twPerm = twDone ? 3'h3 : 3'h4;
    assign twCacheable = twDone ? eC : ~eC;
    assign twModified = !twDone;
    // one answer pulse after a short or long wait
    task automatic answer(ref logic s);
        repeat (slow ? 6 : 1) @(posedge mclk);
        #1 s = 1;
        @(posedge mclk) #1 s = 0;
    endtask
    // translation fetch for the requesting context
    always @(posedge mclk) if (resetn && xlateReq_r) answer(twDone);
    // four doublewords, first resumes, rest in background
    always @(posedge mclk) if (resetn && fillReq_r) begin
        repeat (4) answer(rdDwValid);
    end
    // uncached data arrival or write accept
    always @(posedge mclk) if (resetn && ncReq_r) answer(ncDone);
    // write-back completion
    always @(posedge mclk) if (resetn && wbReq_r) answer(wbDone);
endmodule

//--- bench/data_cache_tag_and_snoop_ctrl_tb.sv
// self-checking bench for the data cache tag and snoop controller
// assumes the partner model answers all far side requests
`timescale 1ns/1ps
// =====================================================================
// bench top
// =====================================================================
module data_cache_tag_and_snoop_ctrl_tb;
    logic mclk = 0, resetn = 0, mmuEnable = 1, dcacheAllowBit = 1;
    logic snoopEnableBit = 0, writeBack = 0, memReq = 0, memWr = 0;
    logic flushInsn = 0, asiStore = 0, dvmaReq = 0, slow = 0, eC = 1;
    logic [31:0] memVa = 32'h0000_0000;
    logic [7:0] memCtx = 8'h05, asiNum = 8'h00;
    logic [29:0] dvmaPa = 30'h0000_0000;
    logic [23:0] ePa = 24'h0a_bcde;
    logic twDone, rdDwValid, ncDone, wbDone, twCacheable, twModified;
    logic [23:0] twPa;
    logic [7:0] twCtx;
    logic [2:0] twPerm;
    logic [11:0] twVa;
    logic stall_r, accDone_r, accFault_r, xlateReq_r, ncReq_r, memWrReq_r;
    logic fillReq_r, wbReq_r, icFlushReq_r, dvmaFwd_r;
    logic [32:0] fillPa_r;
    logic [8:0] wbIdx_r, icFlushIdx_r;
    int fail_count = 0, n_checks = 0, cyc;
    logic sawX, sawF, sawN;
    logic [32:0] fpa;
    logic [7:0] codes [8] = '{8'h00, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
                              8'h15, 8'h37};
    always #10 mclk = ~mclk;
    dcache_tag_snoop_ctrl dut (.mclk, .resetn, .mmuEnable, .dcacheAllowBit,
        .snoopEnableBit, .writeBack, .memReq, .memWr, .memVa, .memCtx,
        .flushInsn, .asiStore, .asiNum, .twDone, .twPa, .twCtx, .twPerm,
        .twCacheable, .twModified, .twVa, .rdDwValid, .ncDone, .wbDone,
        .dvmaReq, .dvmaPa, .stall_r, .accDone_r, .accFault_r, .xlateReq_r,
        .ncReq_r, .memWrReq_r, .fillReq_r, .fillPa_r, .wbReq_r, .wbIdx_r,
        .icFlushReq_r, .icFlushIdx_r, .dvmaFwd_r);
    dcache_pipe_partner far (.mclk, .resetn, .slow, .eC, .memVa, .memCtx,
        .ePa, .xlateReq_r, .fillReq_r, .ncReq_r, .wbReq_r, .twDone,
        .rdDwValid, .ncDone, .wbDone, .twCacheable, .twModified, .twPa,
        .twCtx, .twPerm, .twVa);
    // compare and count
    task automatic chk(input logic [63:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one access, noting requests seen
    task automatic acc(input logic [31:0] va, input logic wr);
        memVa = va;
        memWr = wr;
        memReq = 1;
        cyc = 0;
        {sawX, sawF, sawN} = '0;
        do begin
            @(posedge mclk) #1 cyc++;
            if (fillReq_r && !sawF) fpa = fillPa_r;
            sawX |= xlateReq_r;
            sawF |= fillReq_r;
            sawN |= ncReq_r;
        end while (accDone_r !== 1'b1 && cyc < 300);
        chk(accDone_r, 1);
        memReq = 0;
        repeat (40) @(posedge mclk) #1;
    endtask
    // one device access, cycles to forward
    task automatic device_virtual_access(input logic [29:0] pa);
        dvmaPa = pa;
        dvmaReq = 1;
        cyc = 0;
        do @(posedge mclk) #1 cyc++;
        while (dvmaFwd_r !== 1'b1 && cyc < 100);
        chk(dvmaFwd_r, 1);
        dvmaReq = 0;
        @(posedge mclk) #1;
    endtask
    // miss, fill, then hit and context miss
    task t_fill;
        slow = 1;
        acc(32'h1234_5678, 0);
        chk(sawX, 1);
        chk(fpa, {ePa, 9'h0cf});
        slow = 0;
        acc(32'h1234_5678, 0);
        chk(cyc, 1);
        memCtx = 8'h06;
        acc(32'h1234_5678, 0);
        chk(sawX, 1);
    endtask
    // every flush code and 0x15, then the line must miss again except after 0x15
    task t_flush;
        for (int j = 0; j < 8; j++) begin
            acc(32'h1234_5678, 0);
            dcacheAllowBit = codes[j] != 8'h37;
            asiNum = codes[j];
            {flushInsn, asiStore} = {codes[j] == 8'h00, codes[j] != 8'h00};
            @(posedge mclk) #1 {flushInsn, asiStore, dcacheAllowBit} = 3'h1;
            acc(32'h1234_5678, 0);
            chk(sawF, codes[j] != 8'h15);
        end
    endtask
    // each caching restriction gives an uncached access
    task t_nc;
        for (int k = 0; k < 3; k++) begin
            {eC, mmuEnable, dcacheAllowBit} = ~(3'h4 >> k);
            acc({4'h3 + 4'(k), 28'h000_0040}, k[0]);
            chk({sawN, sawF}, 2'h2);
        end
        {eC, mmuEnable, dcacheAllowBit} = 3'h7;
    endtask
    // snoop off, snoop miss, snoop hit invalidating the line
    task t_snoop;
        acc(32'h1234_5678, 0);
        device_virtual_access({ePa[17:0], 12'h678});
        chk(cyc, 2);
        snoopEnableBit = 1;
        device_virtual_access({~ePa[17:0], 12'h678});
        chk(cyc, 6);
        acc(32'h1234_5678, 0);
        chk(cyc, 1);
        device_virtual_access({ePa[17:0], 12'h678});
        acc(32'h1234_5678, 0);
        chk(sawF, 1);
        snoopEnableBit = 0;
    endtask
    // verdict and end of run
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge mclk);
        #1 resetn = 1;
        @(posedge mclk) #1;
        t_fill();
        t_flush();
        t_nc();
        t_snoop();
        test_done();
    end
    // watchdog
    initial begin
        #400000;
        fail_count++;
        test_done();
    end
endmodule
